// >>> bss_field_model.sv
// Field side: air switch closes once the fan is up to speed, flame follows the valve.
// Assumes the bench enables or spoils each signal to stage faults.
`default_nettype none
module bss_field_model #(
  parameter int AIR_DELAY = 5
) (
  input  wire logic clk,
  input  wire logic fan_on,
  input  wire logic valve_on,
  input  wire logic air_ok,
  input  wire logic flame_ok,
  output var  logic air_proven,
  output var  logic flame
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] spin_reg;
  // A real pressure switch lags the fan, so the sequencer must not expect instant proof.
  always_ff @(posedge clk) begin
    spin_reg   <= !fan_on ? 4'h0 : (spin_reg == 4'hf) ? spin_reg : spin_reg + 4'h1;
    air_proven <= air_ok && fan_on && (spin_reg >= AIR_DELAY[3:0]);
    flame      <= flame_ok && valve_on;
  end
endmodule : bss_field_model
`default_nettype wire

// >>> bss_pkg.sv
// Constants, types and register map of the burner safety sequencer.
// Assumes a 10 MHz system clock; all sequence times are counted in whole seconds.
`default_nettype none

package bss_pkg;

  localparam int CLK_PERIOD_NS   = 100;
  localparam int SEC_NS          = 1_000_000_000;
  localparam int TICK_CYCLES     = SEC_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_NS     = 20_000_000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_NS / CLK_PERIOD_NS;

  localparam logic [11:0] PREPURGE_S   = 12'h00f;  // 15 s
  localparam logic [11:0] WARMUP_S     = 12'h014;  // 20 s
  localparam logic [11:0] TRIAL_S      = 12'h006;  // 6 s
  localparam logic [11:0] IGN_LAMP_S   = 12'h002;  // 2 s
  localparam logic [11:0] POSTPURGE_S  = 12'h01e;  // 30 s
  localparam logic [11:0] AFTERBURN_S  = 12'h002;  // 2 s
  localparam logic [11:0] AIR_WAIT_S   = 12'h12c;  // 5 min
  localparam logic [11:0] AIR_LOCK_S   = 12'h384;  // 15 min
  localparam logic [11:0] FLAME_LOCK_S = 12'he10;  // 1 h
  localparam logic [1:0]  MAX_TRIES    = 2'h3;

  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  STATUS_OFS = 8'h04;
  localparam logic [7:0]  TIMER_OFS  = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int          CTRL_ENABLE_BIT = 0;
  localparam int          ST_STATE_LSB    = 0;
  localparam int          ST_TRIES_LSB    = 4;
  localparam int          ST_CAUSE_LSB    = 6;
  localparam int          ST_LAMPS_LSB    = 8;
  localparam int          ST_DRIVE_LSB    = 16;

  typedef enum logic [3:0] {
    ST_OFF        = 4'h0,
    ST_STANDBY    = 4'h1,
    ST_FAN_WAIT   = 4'h2,
    ST_PREPURGE   = 4'h3,
    ST_WARMUP     = 4'h4,
    ST_TRIAL      = 4'h5,
    ST_RUN        = 4'h6,
    ST_POSTPURGE  = 4'h7,
    ST_TRIP_HOLD  = 4'h8,
    ST_AIR_WAIT   = 4'h9,
    ST_LOCK_FLAME = 4'ha,
    ST_LOCK_AIR   = 4'hb
  } bss_state_t;

  typedef enum logic [1:0] {
    CAUSE_END   = 2'h0,
    CAUSE_FLAME = 2'h1,
    CAUSE_AIR   = 2'h2,
    CAUSE_LIMIT = 2'h3
  } bss_cause_t;

  // Switch inputs, all high when the contact is closed or the condition holds.
  typedef struct packed {
    logic service_on;
    logic flame;
    logic high_limit_ok;
    logic fan_temp_ok;
    logic air_proven;
    logic heat_demand;
  } bss_sw_t;

  typedef struct packed {
    logic circulator;
    logic draft_fan;
    logic igniter;
    logic gas_valve;
  } bss_drive_t;

  // Lamps A to E: power, purge, igniter, valve, flame.
  typedef struct packed {
    logic flame;
    logic valve;
    logic igniter;
    logic purge;
    logic power;
  } bss_lamp_t;

endpackage : bss_pkg

`default_nettype wire

// >>> bss_sequencer.sv
// Burner safety sequencer: light-off, trips, retries, lockouts and lamps, with a
// classic Wishbone slave for control and status.
// Assumes switch inputs arrive asynchronously from field contacts and the clock is 10 MHz.
`default_nettype none

// What this block does
// [R1] Demand drop: valve, circulator off, post purge
// [R2] Flame lamp lingers 2 s, fan runs
// [R3] Post purge end: fan off, standby
// [R4] Fan overtemperature: valve off, 30 s purge
// [R5] Fan trip: circulator on, reclose relights
// [R6] Flame loss: valve, lamps off, purge
// [R7] Three relight tries, then flame lockout blinking
// [R8] Flame lockout clears after one hour
// [R9] Airflow loss: valve, lamps off, purge
// [R10] Wait five minutes for airflow return
// [R11] Airflow lockout blinks purge, clears 15 min
// [R12] Casting switch cuts power externally
// [R13] High limit: valve off, 30 s purge
// [R14] Limit trip: circulator on, reclose relights
// [R15] Circulator follows demand during lockout
// [R16] Demand cycle or service cycle clears lockout
// [R17] Lamps A to E; A lit standby
// [R18] Fan, prove airflow, 15 s prepurge
// [R19] Igniter warm-up 20 s, lamp C
// [R20] 6 s trial, lamp C 2 s, prove flame
// [R21] Inputs synced, debounced; one-second tick
module bss_sequencer #(
  parameter int TICK_CYCLES     = bss_pkg::TICK_CYCLES,
  parameter int DEBOUNCE_CYCLES = bss_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire bss_pkg::bss_sw_t    sw_in,
  output var  bss_pkg::bss_drive_t drive_out,
  output var  bss_pkg::bss_lamp_t  lamp_out,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o
);

  localparam int NSW = $bits(bss_pkg::bss_sw_t);

  logic [NSW-1:0]      sw_sync1_reg;
  logic [NSW-1:0]      sw_sync2_reg;
  logic [NSW-1:0]      sw_clean_reg;
  bss_pkg::bss_sw_t    sw;
  logic [31:0]         tick_cnt_reg;
  logic                tick_reg;
  logic                blink_reg;
  bss_pkg::bss_state_t state_reg;
  bss_pkg::bss_state_t state_next;
  bss_pkg::bss_cause_t cause_reg;
  bss_pkg::bss_cause_t cause_next;
  logic [1:0]          tries_reg;
  logic [1:0]          tries_next;
  logic [11:0]         sec_reg;
  logic [31:0]         ctrl_reg;
  logic                demand;
  logic                trips_ok;
  bss_pkg::bss_drive_t drive_next;
  bss_pkg::bss_lamp_t  lamp_next;

  // A contact must hold a new level for the whole debounce time before it is
  // believed, so chatter on a failing switch cannot toggle the valve.
  genvar gi;
  generate
    for (gi = 0; gi < NSW; gi++) begin : g_sw
      logic [31:0] deb_cnt_reg;
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sw_sync1_reg[gi] <= 1'b0;
          sw_sync2_reg[gi] <= 1'b0;
        end else begin
          sw_sync1_reg[gi] <= sw_in[gi];  // R21
          sw_sync2_reg[gi] <= sw_sync1_reg[gi];
        end
      end
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          deb_cnt_reg      <= 32'h0000_0000;
          sw_clean_reg[gi] <= 1'b0;
        end else if (sw_sync2_reg[gi] == sw_clean_reg[gi]) begin
          deb_cnt_reg <= 32'h0000_0000;
        end else if (deb_cnt_reg >= 32'(DEBOUNCE_CYCLES - 1)) begin
          deb_cnt_reg      <= 32'h0000_0000;
          sw_clean_reg[gi] <= sw_sync2_reg[gi];  // R21
        end else begin
          deb_cnt_reg <= deb_cnt_reg + 32'h0000_0001;
        end
      end
    end
  endgenerate

  assign sw       = sw_clean_reg;
  assign demand   = sw.heat_demand && ctrl_reg[bss_pkg::CTRL_ENABLE_BIT];
  assign trips_ok = sw.fan_temp_ok && sw.high_limit_ok;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
      blink_reg    <= 1'b0;
    end else if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b1;  // R21
      blink_reg    <= ~blink_reg;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg     <= 1'b0;
    end
  end

  // Seconds spent in the present state; restarts on every state change.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_reg <= 12'h000;
    end else if (state_next != state_reg) begin
      sec_reg <= 12'h000;
    end else if (tick_reg && sec_reg != 12'hfff) begin
      sec_reg <= sec_reg + 12'h001;
    end
  end

  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    tries_next = tries_reg;
    case (state_reg)
      bss_pkg::ST_OFF: begin
        state_next = bss_pkg::ST_STANDBY;
      end
      bss_pkg::ST_STANDBY: begin
        tries_next = 2'h0;
        if (demand) begin
          state_next = trips_ok ? bss_pkg::ST_FAN_WAIT : bss_pkg::ST_TRIP_HOLD;
        end
      end
      bss_pkg::ST_FAN_WAIT: begin
        if (sw.air_proven) begin
          state_next = bss_pkg::ST_PREPURGE;  // R18
        end
      end
      bss_pkg::ST_PREPURGE: begin
        if (sec_reg >= bss_pkg::PREPURGE_S) begin
          state_next = bss_pkg::ST_WARMUP;  // R19
        end
      end
      bss_pkg::ST_WARMUP: begin
        if (sec_reg >= bss_pkg::WARMUP_S) begin
          state_next = bss_pkg::ST_TRIAL;  // R20
        end
      end
      bss_pkg::ST_TRIAL: begin
        if (sec_reg >= bss_pkg::TRIAL_S) begin
          if (sw.flame) begin
            state_next = bss_pkg::ST_RUN;  // R20
          end else begin
            state_next = bss_pkg::ST_POSTPURGE;
            cause_next = bss_pkg::CAUSE_FLAME;
          end
        end
      end
      bss_pkg::ST_RUN: begin
        if (!sw.flame) begin
          state_next = bss_pkg::ST_POSTPURGE;  // R6
          cause_next = bss_pkg::CAUSE_FLAME;
        end
      end
      bss_pkg::ST_POSTPURGE: begin
        if (sec_reg >= bss_pkg::POSTPURGE_S) begin
          if (!demand || cause_reg == bss_pkg::CAUSE_END) begin
            state_next = bss_pkg::ST_STANDBY;  // R3
          end else begin
            case (cause_reg)
              bss_pkg::CAUSE_FLAME: begin
                if (tries_reg >= bss_pkg::MAX_TRIES) begin
                  state_next = bss_pkg::ST_LOCK_FLAME;  // R7
                end else begin
                  tries_next = tries_reg + 2'h1;  // R7
                  state_next = bss_pkg::ST_FAN_WAIT;
                end
              end
              bss_pkg::CAUSE_AIR:   state_next = bss_pkg::ST_AIR_WAIT;  // R10
              default:              state_next = bss_pkg::ST_TRIP_HOLD;  // R5 R14
            endcase
          end
        end
      end
      bss_pkg::ST_TRIP_HOLD: begin
        if (!demand) begin
          state_next = bss_pkg::ST_STANDBY;
        end else if (trips_ok) begin
          state_next = bss_pkg::ST_FAN_WAIT;  // R5 R14
        end
      end
      bss_pkg::ST_AIR_WAIT: begin
        if (!demand) begin
          state_next = bss_pkg::ST_STANDBY;
        end else if (sw.air_proven) begin
          state_next = bss_pkg::ST_PREPURGE;  // R10
        end else if (sec_reg >= bss_pkg::AIR_WAIT_S) begin
          state_next = bss_pkg::ST_LOCK_AIR;  // R11
        end
      end
      bss_pkg::ST_LOCK_FLAME: begin
        if (!demand || sec_reg >= bss_pkg::FLAME_LOCK_S) begin
          state_next = bss_pkg::ST_STANDBY;  // R8 R16
        end
      end
      bss_pkg::ST_LOCK_AIR: begin
        if (!demand || sec_reg >= bss_pkg::AIR_LOCK_S) begin
          state_next = bss_pkg::ST_STANDBY;  // R11 R16
        end
      end
      default: begin
        state_next = bss_pkg::ST_OFF;
      end
    endcase
    // Safety trips override whatever the firing sequence asked for above.
    if (state_reg inside {bss_pkg::ST_FAN_WAIT, bss_pkg::ST_PREPURGE, bss_pkg::ST_WARMUP,
                          bss_pkg::ST_TRIAL, bss_pkg::ST_RUN}) begin
      if (!demand) begin
        state_next = bss_pkg::ST_POSTPURGE;  // R1
        cause_next = bss_pkg::CAUSE_END;
      end else if (!trips_ok) begin
        state_next = bss_pkg::ST_POSTPURGE;  // R4 R13
        cause_next = bss_pkg::CAUSE_LIMIT;
      end else if (!sw.air_proven && state_reg != bss_pkg::ST_FAN_WAIT) begin
        state_next = bss_pkg::ST_POSTPURGE;  // R9
        cause_next = bss_pkg::CAUSE_AIR;
      end
    end
    // Service switch off drops everything; turning it back on restarts clean.
    if (!sw.service_on) begin
      state_next = bss_pkg::ST_OFF;  // R16
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= bss_pkg::ST_OFF;
      cause_reg <= bss_pkg::CAUSE_END;
      tries_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
      tries_reg <= tries_next;
    end
  end

  always_comb begin
    drive_next = '0;
    lamp_next  = '0;
    lamp_next.power = (state_reg != bss_pkg::ST_OFF);  // R17
    drive_next.circulator = demand && state_reg != bss_pkg::ST_OFF;  // R1 R5 R14 R15
    case (state_reg)
      bss_pkg::ST_FAN_WAIT, bss_pkg::ST_AIR_WAIT: begin
        drive_next.draft_fan = 1'b1;  // R18
      end
      bss_pkg::ST_PREPURGE: begin
        drive_next.draft_fan = 1'b1;
        lamp_next.purge      = 1'b1;  // R18
      end
      bss_pkg::ST_WARMUP: begin
        drive_next.draft_fan = 1'b1;
        drive_next.igniter   = 1'b1;  // R19
        lamp_next.igniter    = 1'b1;
      end
      bss_pkg::ST_TRIAL: begin
        drive_next.draft_fan = 1'b1;
        drive_next.gas_valve = 1'b1;  // R20
        drive_next.igniter   = (sec_reg < bss_pkg::IGN_LAMP_S);
        lamp_next.igniter    = (sec_reg < bss_pkg::IGN_LAMP_S);  // R20
        lamp_next.valve      = 1'b1;
        lamp_next.flame      = sw.flame;
      end
      bss_pkg::ST_RUN: begin
        drive_next.draft_fan = 1'b1;
        drive_next.gas_valve = 1'b1;
        lamp_next.valve      = 1'b1;
        lamp_next.flame      = 1'b1;
      end
      bss_pkg::ST_POSTPURGE: begin
        drive_next.draft_fan = 1'b1;  // R2
        lamp_next.purge      = 1'b1;  // R1
        // Only a flame that was actually lit lingers; a purge that follows an
        // aborted light-off must not show a burning flame.
        lamp_next.flame      = lamp_out.flame && (cause_reg == bss_pkg::CAUSE_END) &&
                               (sec_reg < bss_pkg::AFTERBURN_S);  // R2
      end
      bss_pkg::ST_LOCK_FLAME: begin
        lamp_next.valve = blink_reg;  // R7
      end
      bss_pkg::ST_LOCK_AIR: begin
        lamp_next.purge = blink_reg;  // R11
      end
      default: begin
        lamp_next.flame = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_out <= '0;
      lamp_out  <= '0;
    end else begin
      drive_out <= drive_next;
      lamp_out  <= lamp_next;
    end
  end

  // Wishbone: ack follows one cycle after the strobe; a write lands at the ack edge.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= bss_pkg::CTRL_RESET;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
                 wb_adr_i == bss_pkg::CTRL_OFS && wb_sel_i[0]) begin
      ctrl_reg <= {31'h0000_0000, wb_dat_i[bss_pkg::CTRL_ENABLE_BIT]};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      case (wb_adr_i)
        bss_pkg::CTRL_OFS:   wb_dat_o <= ctrl_reg;
        bss_pkg::STATUS_OFS: wb_dat_o <= {12'h000, drive_out, 3'h0, lamp_out,
                                          cause_reg, tries_reg, state_reg};
        bss_pkg::TIMER_OFS:  wb_dat_o <= {20'h0_0000, sec_reg};
        default:             wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule : bss_sequencer

`default_nettype wire

// >>> bss_sequencer_assertions.sv
// Port-level checks on the burner safety sequencer.
// Assumes short debounce so a settled switch reaches the outputs within 8 cycles.
`default_nettype none
module bss_sequencer_assertions #(
  parameter int TICK_CYCLES     = 20,
  parameter int DEBOUNCE_CYCLES = 3
) (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire bss_pkg::bss_sw_t    sw_in,
  input wire bss_pkg::bss_drive_t drive_out,
  input wire bss_pkg::bss_lamp_t  lamp_out,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_VALVE_FAN: assert property (drive_out.gas_valve |-> drive_out.draft_fan)
    else $error("valve open without fan");
  AST_VALVE_LAMP: assert property (drive_out.gas_valve |-> lamp_out.valve)
    else $error("valve open with lamp dark");
  AST_IGN_LAMP: assert property (drive_out.igniter == lamp_out.igniter)
    else $error("igniter and its lamp differ");
  AST_OFF_DARK: assert property (!lamp_out.power |-> drive_out == 4'h0)
    else $error("output driven while unpowered");
  AST_DEMAND_OFF: assert property (!sw_in.heat_demand [*8] |=>
    !drive_out.gas_valve && !drive_out.circulator) else $error("demand gone, still on");
  AST_FAN_TRIP: assert property (!sw_in.fan_temp_ok [*8] |=> !drive_out.gas_valve)
    else $error("valve open in fan trip");
  AST_LIMIT_TRIP: assert property (!sw_in.high_limit_ok [*8] |=> !drive_out.gas_valve)
    else $error("valve open in limit trip");
  AST_AIR_TRIP: assert property (!sw_in.air_proven [*8] |=> !drive_out.gas_valve)
    else $error("valve open without airflow");
  AST_CIRC_CAUSE: assert property ($rose(drive_out.circulator) |->
    $past(sw_in.heat_demand, 3)) else $error("circulator without demand");
endmodule : bss_sequencer_assertions
bind bss_sequencer bss_sequencer_assertions #(
  .TICK_CYCLES(TICK_CYCLES),
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) u_chk (
  .clk(clk),
  .reset_n(reset_n),
  .sw_in(sw_in),
  .drive_out(drive_out),
  .lamp_out(lamp_out),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o)
);
`default_nettype wire

// >>> bss_sequencer_tb.sv
// Self-checking bench: drives field switches and polls state over Wishbone.
// Assumes a 20-cycle tick and 3-cycle debounce so sequences run in thousands of cycles.
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module bss_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 20;
  logic                clk, reset_n, demand, service, fan_ok, limit_ok, air_en, flame_en;
  logic                air_m, flame_m, blink;
  bss_pkg::bss_drive_t drive_out;
  bss_pkg::bss_lamp_t  lamp_out;
  logic                wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]          wb_adr;
  logic [3:0]          wb_sel;
  logic [31:0]         wb_wdat, wb_rdat, rd;
  int                  mismatches = 0;
  int                  check_count = 0;
  int                  cycles = 0;

  bss_sequencer #(.TICK_CYCLES(TICK), .DEBOUNCE_CYCLES(3)) uut (
    .clk(clk), .reset_n(reset_n),
    .sw_in({service, flame_m, limit_ok, fan_ok, air_m, demand}),
    .drive_out(drive_out), .lamp_out(lamp_out), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  bss_field_model u_field (.clk(clk), .fan_on(drive_out.draft_fan),
    .valve_on(drive_out.gas_valve), .air_ok(air_en), .flame_ok(flame_en),
    .air_proven(air_m), .flame(flame_m));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // Entered and left just after a rising edge; leaves one idle cycle behind.
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= dat;
    do @(posedge clk); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask : wb_xfer

  task automatic wait_state(input bss_pkg::bss_state_t s);
    int n;
    n = 0;
    do begin
      wb_xfer(1'b0, bss_pkg::STATUS_OFS, 32'h0);
      n++;
    end while (rd[3:0] !== s && n < 4000);
    `CHK(rd[3:0], s)
  endtask : wait_state

  task automatic light_off();
    demand <= 1'b1;
    wait_state(bss_pkg::ST_PREPURGE);
    `CHK({lamp_out.purge, drive_out.draft_fan}, 2'h3)
    wait_state(bss_pkg::ST_WARMUP);
    `CHK({lamp_out.purge, lamp_out.igniter, drive_out.igniter}, 3'h3)
    wait_state(bss_pkg::ST_TRIAL);
    `CHK({lamp_out.valve, drive_out.gas_valve}, 2'h3)
    wait_state(bss_pkg::ST_RUN);
    `CHK({lamp_out.igniter, drive_out.igniter}, 2'h0)
  endtask : light_off

  initial begin
    {reset_n, demand, wb_cyc, wb_stb, wb_we} = 5'h00;
    {service, fan_ok, limit_ok, air_en, flame_en} = 5'h1f;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_wdat = 32'h0;
    repeat (2) @(posedge clk);
    `CHK({drive_out, lamp_out}, 9'h000)
    reset_n <= 1'b1;
    wait_state(bss_pkg::ST_STANDBY);
    `CHK(lamp_out, 5'h01)
    wb_xfer(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    // A write without the low byte lane selected must leave the enable alone.
    wb_sel <= 4'he;
    wb_xfer(1'b1, bss_pkg::CTRL_OFS, 32'h0);
    wb_sel <= 4'hf;
    wb_xfer(1'b0, bss_pkg::CTRL_OFS, 32'h0);
    `CHK(rd, bss_pkg::CTRL_RESET)
    wb_xfer(1'b1, bss_pkg::CTRL_OFS, 32'h0);
    demand <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(drive_out, 4'h0)
    wb_xfer(1'b1, bss_pkg::CTRL_OFS, 32'h1);
    light_off();
    for (int k = 0; k < 3; k++) begin
      {limit_ok, fan_ok, air_en} <= ~(3'h4 >> k);
      wait_state(bss_pkg::ST_POSTPURGE);
      `CHK({drive_out.circulator, drive_out.draft_fan, drive_out.gas_valve}, 3'h6)
      `CHK(lamp_out.valve, 1'b0)
      if (k != 1) `CHK(lamp_out.flame, 1'b0)
      {limit_ok, fan_ok, air_en} <= 3'h7;
      wait_state(bss_pkg::ST_RUN);
    end
    demand <= 1'b0;
    wait_state(bss_pkg::ST_POSTPURGE);
    `CHK({drive_out, lamp_out.valve, lamp_out.purge}, 6'h11)
    `CHK({lamp_out.flame, drive_out.draft_fan}, 2'h3)
    repeat (28 * TICK) @(posedge clk);
    `CHK({lamp_out.flame, drive_out.draft_fan}, 2'h1)
    wait_state(bss_pkg::ST_STANDBY);
    `CHK(drive_out.draft_fan, 1'b0)
    light_off();
    flame_en <= 1'b0;
    wait_state(bss_pkg::ST_POSTPURGE);
    `CHK({drive_out.gas_valve, lamp_out.valve, lamp_out.flame}, 3'h0)
    wait_state(bss_pkg::ST_LOCK_FLAME);
    blink = lamp_out.valve;
    repeat (TICK) @(posedge clk);
    `CHK({lamp_out.valve, drive_out.circulator}, {~blink, 1'b1})
    demand <= 1'b0;
    wait_state(bss_pkg::ST_STANDBY);
    flame_en <= 1'b1;
    light_off();
    air_en <= 1'b0;
    wait_state(bss_pkg::ST_AIR_WAIT);
    repeat (280 * TICK) @(posedge clk);
    wb_xfer(1'b0, bss_pkg::STATUS_OFS, 32'h0);
    `CHK(rd[3:0], bss_pkg::ST_AIR_WAIT)
    wait_state(bss_pkg::ST_LOCK_AIR);
    blink = lamp_out.purge;
    repeat (TICK) @(posedge clk);
    `CHK({lamp_out.purge, drive_out.circulator}, {~blink, 1'b1})
    service <= 1'b0;
    wait_state(bss_pkg::ST_OFF);
    `CHK({drive_out, lamp_out}, 9'h000)
    service <= 1'b1;
    air_en <= 1'b1;
    wait_state(bss_pkg::ST_RUN);
    // The casting switch cutting supply power is staged as a reset while firing.
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({drive_out, lamp_out}, 9'h000)
    reset_n <= 1'b1;
    wait_state(bss_pkg::ST_PREPURGE);
    `CHK({lamp_out.power, lamp_out.purge}, 2'h3)
    end_sim();
  end
endmodule : bss_sequencer_tb
`default_nettype wire
